//--- verilog/cbc_regs.sv
// Charger and backlight configuration register bank
`include "cbc_defs.svh"
module cbc_regs #(
    parameter logic [19:0] DIM_HALF0 = 20'(`CBC_HALF_CYC(`CBC_DIM_F0_HZ)),
    parameter logic [19:0] DIM_HALF1 = 20'(`CBC_HALF_CYC(`CBC_DIM_F1_HZ)),
    parameter logic [19:0] DIM_HALF2 = 20'(`CBC_HALF_CYC(`CBC_DIM_F2_HZ)),
    parameter logic [19:0] DIM_HALF3 = 20'(`CBC_HALF_CYC(`CBC_DIM_F3_HZ)),
    parameter logic [7:0]  TIMER_DIV = 8'(`CBC_TIMER_TICK_DIV)
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Register access from the serial control interface
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    output logic             REG_RVALID,
    // Regulation loop status pins
    input  wire logic        THERMAL_LOOP_ACTIVE,
    input  wire logic        POWER_PATH_CURRENT_REDUCTION,
    // Charger settings
    output logic             SAFETY_TIMER_TICK,
    output logic             TIMER_SLOWDOWN_ENABLE,
    output logic             PRECHARGE_TRANSITION_SELECT,
    output logic      [12:0] PRECHARGE_TRANSITION_MV,
    output logic      [1:0]  CHARGE_TARGET_VOLTAGE,
    output logic      [12:0] CHARGE_TARGET_MV,
    output logic      [1:0]  CHARGE_CURRENT_SELECT,
    output logic      [9:0]  CHARGE_CURRENT_MA,
    output logic      [1:0]  POWER_PATH_THRESHOLD,
    output logic      [12:0] POWER_PATH_THRESHOLD_MV,
    output logic             PRECHARGE_TIME_SELECT,
    output logic      [6:0]  PRECHARGE_TIME_MIN,
    output logic      [1:0]  TERMINATION_FACTOR,
    output logic      [7:0]  TERMINATION_FACTOR_PCT10,
    output logic      [16:0] TERMINATION_CURRENT_UA,
    output logic             CHARGE_TEMPERATURE_WINDOW,
    output logic      [6:0]  CHARGE_TEMPERATURE_MAX_C,
    // Backlight settings
    output logic             LED_SINK1_ENABLE,
    output logic             LED_SINK2_ENABLE,
    output logic             SINK_LEVEL_SELECT,
    output logic      [1:0]  DIMMING_FREQUENCY,
    output logic      [10:0] DIMMING_FREQUENCY_HZ,
    output logic             DIMMING_WAVE
);
    import cbc_pkg::*;

    cbc_state_t st;
    cbc_state_t next_st;
    logic       slow;

    // ****************************************
    // Register access, pin sync and decode
    // ****************************************
    always_comb
    begin
        next_st = st;
        next_st.rvalid = REG_RD;

        // Writes land at the edge ending the write cycle
        if (REG_WR)
        begin
            case (REG_ADDR)
                `CBC_OFF_SETUP_B:     next_st.setup_b = REG_WDATA;
                `CBC_OFF_SETUP_C:     next_st.setup_c = REG_WDATA;
                `CBC_OFF_BACKLIGHT_A: next_st.backlight = REG_WDATA[3:0];
                default:              next_st.setup_b = st.setup_b;
            endcase
        end

        // Read data; unmapped offsets read zero
        if (REG_RD)
        begin
            case (REG_ADDR)
                `CBC_OFF_SETUP_B:     next_st.rdata = st.setup_b;
                `CBC_OFF_SETUP_C:     next_st.rdata = st.setup_c;
                `CBC_OFF_BACKLIGHT_A: next_st.rdata = {4'h0, st.backlight};
                default:              next_st.rdata = 8'h00;
            endcase
        end

        // Three-stage sync, level taken when stages two and three agree
        next_st.sync1 = {POWER_PATH_CURRENT_REDUCTION, THERMAL_LOOP_ACTIVE};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < 2; i++)
        begin
            if (st.sync2[i] == st.sync3[i])
                next_st.loop_level[i] = st.sync3[i];
        end

        // Charge target voltage
        case (st.setup_b[`CBC_B_TARGET_HI:`CBC_B_TARGET_LO])
            2'h0:    next_st.target_mv = 13'd4100;
            2'h1:    next_st.target_mv = 13'd4150;
            default: next_st.target_mv = 13'd4200;
        endcase

        next_st.prechg_mv = st.setup_b[`CBC_B_PRECHG_SEL] ? 13'd2500 : 13'd2900;

        // Charge current
        case (st.setup_c[`CBC_C_CURRENT_HI:`CBC_C_CURRENT_LO])
            2'h0:    next_st.current_ma = 10'd300;
            2'h1:    next_st.current_ma = 10'd400;
            2'h2:    next_st.current_ma = 10'd500;
            default: next_st.current_ma = 10'd700;
        endcase

        // Power-path threshold
        case (st.setup_c[`CBC_C_PPATH_HI:`CBC_C_PPATH_LO])
            2'h0:    next_st.ppath_mv = 13'd3500;
            2'h1:    next_st.ppath_mv = 13'd3750;
            2'h2:    next_st.ppath_mv = 13'd4000;
            default: next_st.ppath_mv = 13'd4250;
        endcase

        next_st.prechg_min = st.setup_c[`CBC_C_PRECHG_TIME] ? 7'd60 : 7'd30;

        // Termination factor in tenths of a percent
        case (st.setup_c[`CBC_C_TERM_HI:`CBC_C_TERM_LO])
            2'h0:    next_st.term_pct10 = 8'd25;
            2'h1:    next_st.term_pct10 = 8'd75;
            2'h2:    next_st.term_pct10 = 8'd150;
            default: next_st.term_pct10 = 8'd180;
        endcase

        // mA times tenths of a percent gives microamps
        next_st.term_ua = 17'(st.current_ma * st.term_pct10);

        next_st.temp_max_c = st.setup_c[`CBC_C_TEMP_WINDOW] ? 7'd60 : 7'd45;

        // Dimming frequency
        case (st.backlight[`CBC_A_DIM_HI:`CBC_A_DIM_LO])
            2'h0:    next_st.dim_hz = 11'd100;
            2'h1:    next_st.dim_hz = 11'd200;
            2'h2:    next_st.dim_hz = 11'd500;
            default: next_st.dim_hz = 11'd1000;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            st <= '0;
            st.setup_b <= `CBC_RST_SETUP_B;
            st.setup_c <= `CBC_RST_SETUP_C;
            st.backlight <= 4'(`CBC_RST_BACKLIGHT_A & `CBC_BACKLIGHT_MASK);
            st.target_mv <= 13'd4100;
            st.prechg_mv <= 13'd2900;
            st.current_ma <= 10'd500;
            st.ppath_mv <= 13'd4250;
            st.prechg_min <= 7'd30;
            st.term_pct10 <= 8'd75;
            st.term_ua <= 17'd37500;
            st.temp_max_c <= 7'd45;
            st.dim_hz <= 11'd200;
        end
        else
            st <= next_st;
    end

    // ****************************************
    // Safety timer clocking
    // ****************************************
    assign slow = st.setup_b[`CBC_B_SLOWDOWN] & (|st.loop_level);

    cbc_timer_div #(
        .TICK_DIV (TIMER_DIV)
    ) u_timer (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .slow  (slow),
        .tick  (SAFETY_TIMER_TICK)
    );

    // ****************************************
    // Dimming waveform
    // ****************************************
    cbc_dim_gen #(
        .HALF0 (DIM_HALF0),
        .HALF1 (DIM_HALF1),
        .HALF2 (DIM_HALF2),
        .HALF3 (DIM_HALF3)
    ) u_dim (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .sel   (st.backlight[`CBC_A_DIM_HI:`CBC_A_DIM_LO]),
        .wave  (DIMMING_WAVE)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign REG_RDATA = st.rdata;
    assign REG_RVALID = st.rvalid;
    assign TIMER_SLOWDOWN_ENABLE = st.setup_b[`CBC_B_SLOWDOWN];
    assign PRECHARGE_TRANSITION_SELECT = st.setup_b[`CBC_B_PRECHG_SEL];
    assign PRECHARGE_TRANSITION_MV = st.prechg_mv;
    assign CHARGE_TARGET_VOLTAGE = st.setup_b[`CBC_B_TARGET_HI:`CBC_B_TARGET_LO];
    assign CHARGE_TARGET_MV = st.target_mv;
    assign CHARGE_CURRENT_SELECT = st.setup_c[`CBC_C_CURRENT_HI:`CBC_C_CURRENT_LO];
    assign CHARGE_CURRENT_MA = st.current_ma;
    assign POWER_PATH_THRESHOLD = st.setup_c[`CBC_C_PPATH_HI:`CBC_C_PPATH_LO];
    assign POWER_PATH_THRESHOLD_MV = st.ppath_mv;
    assign PRECHARGE_TIME_SELECT = st.setup_c[`CBC_C_PRECHG_TIME];
    assign PRECHARGE_TIME_MIN = st.prechg_min;
    assign TERMINATION_FACTOR = st.setup_c[`CBC_C_TERM_HI:`CBC_C_TERM_LO];
    assign TERMINATION_FACTOR_PCT10 = st.term_pct10;
    assign TERMINATION_CURRENT_UA = st.term_ua;
    assign CHARGE_TEMPERATURE_WINDOW = st.setup_c[`CBC_C_TEMP_WINDOW];
    assign CHARGE_TEMPERATURE_MAX_C = st.temp_max_c;
    assign LED_SINK1_ENABLE = st.backlight[`CBC_A_SINK_EN];
    assign LED_SINK2_ENABLE = st.backlight[`CBC_A_SINK_EN];
    assign SINK_LEVEL_SELECT = st.backlight[`CBC_A_LEVEL_SEL];
    assign DIMMING_FREQUENCY = st.backlight[`CBC_A_DIM_HI:`CBC_A_DIM_LO];
    assign DIMMING_FREQUENCY_HZ = st.dim_hz;
endmodule

//--- verilog/cbc_defs.svh
// Offsets, field positions, reset values and timing counts of the config bank
`ifndef CBC_DEFS_SVH
`define CBC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CBC_OFF_SETUP_B      8'h05
`define CBC_OFF_SETUP_C      8'h06
`define CBC_OFF_BACKLIGHT_A  8'h07

// ****************************************
// Reset values
// ****************************************
`define CBC_RST_SETUP_B      8'h80
`define CBC_RST_SETUP_C      8'hb2
`define CBC_RST_BACKLIGHT_A  8'hb1
`define CBC_BACKLIGHT_MASK   8'h0f

// ****************************************
// Field positions
// ****************************************
`define CBC_B_SLOWDOWN       7
`define CBC_B_PRECHG_SEL     6
`define CBC_B_TARGET_HI      5
`define CBC_B_TARGET_LO      4
`define CBC_C_CURRENT_HI     7
`define CBC_C_CURRENT_LO     6
`define CBC_C_PPATH_HI       5
`define CBC_C_PPATH_LO       4
`define CBC_C_PRECHG_TIME    3
`define CBC_C_TERM_HI        2
`define CBC_C_TERM_LO        1
`define CBC_C_TEMP_WINDOW    0
`define CBC_A_SINK_EN        3
`define CBC_A_LEVEL_SEL      2
`define CBC_A_DIM_HI         1
`define CBC_A_DIM_LO         0

// ****************************************
// Timing
// ****************************************
`define CBC_CLK_HZ           200000000
`define CBC_DIM_F0_HZ        100
`define CBC_DIM_F1_HZ        200
`define CBC_DIM_F2_HZ        500
`define CBC_DIM_F3_HZ        1000
`define CBC_HALF_CYC(f)      (`CBC_CLK_HZ / (2 * (f)))
`define CBC_TIMER_TICK_DIV   200

`endif

//--- verilog/cbc_pkg.sv
// Types shared by the charger and backlight config bank
package cbc_pkg;

    typedef struct packed {
        logic [7:0] cnt;
        logic       phase;
        logic       tick;
    } cbc_tdiv_t;

    typedef struct packed {
        logic [19:0] cnt;
        logic        wave;
    } cbc_dim_t;

    typedef struct packed {
        logic [7:0]  setup_b;
        logic [7:0]  setup_c;
        logic [3:0]  backlight;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic [1:0]  sync3;
        logic [1:0]  loop_level;
        logic [12:0] target_mv;
        logic [12:0] prechg_mv;
        logic [9:0]  current_ma;
        logic [12:0] ppath_mv;
        logic [6:0]  prechg_min;
        logic [7:0]  term_pct10;
        logic [16:0] term_ua;
        logic [6:0]  temp_max_c;
        logic [10:0] dim_hz;
    } cbc_state_t;

endpackage

//--- verilog/cbc_timer_div.sv
// Safety timer tick generator with optional half-speed mode
`include "cbc_defs.svh"
module cbc_timer_div #(
    parameter logic [7:0] TICK_DIV = 8'(`CBC_TIMER_TICK_DIV)
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic slow,
    // Tick out
    output logic      tick
);
    import cbc_pkg::*;

    cbc_tdiv_t st;
    cbc_tdiv_t next_st;
    logic      base;

    always_comb
    begin
        next_st = st;
        base = (st.cnt == TICK_DIV - 8'h01);
        next_st.cnt = base ? 8'h00 : st.cnt + 8'h01;
        next_st.tick = 1'b0;
        if (base)
        begin
            next_st.phase = ~st.phase;
            next_st.tick = slow ? st.phase : 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
endmodule

//--- verilog/cbc_dim_gen.sv
// Dimming waveform generator with four selectable frequencies
`include "cbc_defs.svh"
module cbc_dim_gen #(
    parameter logic [19:0] HALF0 = 20'(`CBC_HALF_CYC(`CBC_DIM_F0_HZ)),
    parameter logic [19:0] HALF1 = 20'(`CBC_HALF_CYC(`CBC_DIM_F1_HZ)),
    parameter logic [19:0] HALF2 = 20'(`CBC_HALF_CYC(`CBC_DIM_F2_HZ)),
    parameter logic [19:0] HALF3 = 20'(`CBC_HALF_CYC(`CBC_DIM_F3_HZ))
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Frequency select
    input  wire logic [1:0] sel,
    // Waveform out
    output logic            wave
);
    import cbc_pkg::*;

    cbc_dim_t    st;
    cbc_dim_t    next_st;
    logic [19:0] half;

    always_comb
    begin
        next_st = st;
        case (sel)
            2'h0:    half = HALF0;
            2'h1:    half = HALF1;
            2'h2:    half = HALF2;
            default: half = HALF3;
        endcase
        if (st.cnt >= half - 20'h00001)
        begin
            next_st.cnt = 20'h00000;
            next_st.wave = ~st.wave;
        end
        else
            next_st.cnt = st.cnt + 20'h00001;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign wave = st.wave;
endmodule

//--- sim/cbc_regs_checker.sv
// Concurrent checks on the config bank ports
`include "cbc_defs.svh"
// ****************
// Checker
// ****************
module cbc_regs_checker #(
    parameter logic [7:0] TIMER_DIV = 8'(`CBC_TIMER_TICK_DIV)
) (
    // Clock, reset and register access
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic [7:0]  REG_RDATA,
    input  wire logic        REG_RVALID,
    // Settings
    input  wire logic        SAFETY_TIMER_TICK,
    input  wire logic        TIMER_SLOWDOWN_ENABLE,
    input  wire logic        PRECHARGE_TRANSITION_SELECT,
    input  wire logic [1:0]  CHARGE_TARGET_VOLTAGE,
    input  wire logic [12:0] CHARGE_TARGET_MV,
    input  wire logic [1:0]  CHARGE_CURRENT_SELECT,
    input  wire logic [9:0]  CHARGE_CURRENT_MA,
    input  wire logic [1:0]  POWER_PATH_THRESHOLD,
    input  wire logic        PRECHARGE_TIME_SELECT,
    input  wire logic [1:0]  TERMINATION_FACTOR,
    input  wire logic        CHARGE_TEMPERATURE_WINDOW,
    input  wire logic        SINK_LEVEL_SELECT,
    input  wire logic [7:0]  TERMINATION_FACTOR_PCT10,
    input  wire logic [16:0] TERMINATION_CURRENT_UA,
    input  wire logic        LED_SINK1_ENABLE,
    input  wire logic        LED_SINK2_ENABLE,
    input  wire logic [1:0]  DIMMING_FREQUENCY,
    input  wire logic [10:0] DIMMING_FREQUENCY_HZ
);
    localparam logic [12:0] TV [4] = '{13'h1004, 13'h1036, 13'h1068, 13'h1068};
    localparam logic [9:0]  MA [4] = '{10'h12c, 10'h190, 10'h1f4, 10'h2bc};
    localparam logic [10:0] HZ [4] = '{11'h064, 11'h0c8, 11'h1f4, 11'h3e8};
    logic [8:0] gap;
    logic       seen;

    // Cycles since the last timer tick
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            gap  <= 9'h000;
            seen <= 1'b0;
        end
        else
        begin
            gap  <= SAFETY_TIMER_TICK ? 9'h000 : gap + 9'h001;
            seen <= seen | SAFETY_TIMER_TICK;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    chk_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read answer missing");
    chk_write_setup_b: assert property (
        REG_WR && REG_ADDR == `CBC_OFF_SETUP_B |=> 8'({TIMER_SLOWDOWN_ENABLE,
        PRECHARGE_TRANSITION_SELECT, CHARGE_TARGET_VOLTAGE}) == ($past(REG_WDATA) >> 4))
        else $error("setup b fields not written");
    chk_write_setup_c: assert property (
        REG_WR && REG_ADDR == `CBC_OFF_SETUP_C |=> {CHARGE_CURRENT_SELECT,
        POWER_PATH_THRESHOLD, PRECHARGE_TIME_SELECT, TERMINATION_FACTOR,
        CHARGE_TEMPERATURE_WINDOW} == $past(REG_WDATA))
        else $error("setup c fields not written");
    chk_write_backlight: assert property (
        REG_WR && REG_ADDR == `CBC_OFF_BACKLIGHT_A |=> {LED_SINK1_ENABLE,
        SINK_LEVEL_SELECT, DIMMING_FREQUENCY} == 4'($past(REG_WDATA)))
        else $error("backlight fields not written");
    chk_target_decode: assert property (
        CHARGE_TARGET_MV == TV[$past(CHARGE_TARGET_VOLTAGE)])
        else $error("target voltage decode wrong");
    chk_current_decode: assert property (
        CHARGE_CURRENT_MA == MA[$past(CHARGE_CURRENT_SELECT)])
        else $error("charge current decode wrong");
    chk_term_product: assert property (
        TERMINATION_CURRENT_UA == 17'($past(CHARGE_CURRENT_MA))
        * 17'($past(TERMINATION_FACTOR_PCT10)))
        else $error("termination current wrong");
    chk_dim_decode: assert property (
        DIMMING_FREQUENCY_HZ == HZ[$past(DIMMING_FREQUENCY)])
        else $error("dimming frequency decode wrong");
    chk_sink_pair: assert property (LED_SINK1_ENABLE == LED_SINK2_ENABLE)
        else $error("sinks differ");
    chk_bl_upper: assert property (
        REG_RD && REG_ADDR == `CBC_OFF_BACKLIGHT_A |=> REG_RDATA[7:4] == 4'h0)
        else $error("reserved backlight bits not zero");
    chk_tick_spacing: assert property (
        SAFETY_TIMER_TICK && seen |-> gap == {1'b0, TIMER_DIV} - 9'h001
        || gap == {TIMER_DIV, 1'b0} - 9'h001)
        else $error("timer tick spacing wrong");

    cover property (REG_WR && REG_ADDR == `CBC_OFF_SETUP_C);
    cover property (REG_RD && REG_ADDR == `CBC_OFF_BACKLIGHT_A);
    cover property (SAFETY_TIMER_TICK && gap == {TIMER_DIV, 1'b0} - 9'h001);
endmodule

bind cbc_regs cbc_regs_checker #(.TIMER_DIV(TIMER_DIV)) cbc_regs_checker_i (.*);

//--- sim/cbc_host.sv
// Host side model issuing single-byte register accesses
// ****************
// Host model
// ****************
module cbc_host (
    // Clock
    input  wire logic       clk,
    // Register access
    output logic            wr,
    output logic            rd,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // One byte per write, lines scrambled once released
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(negedge clk);
        d = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask
endmodule

//--- sim/cbc_regs_test.sv
// Self-checking bench of the config bank
`include "cbc_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
// ****************
// Bench
// ****************
module cbc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] TV [4] = '{13'h1004, 13'h1036, 13'h1068, 13'h1068};
    localparam logic [9:0]  MA [4] = '{10'h12c, 10'h190, 10'h1f4, 10'h2bc};
    localparam logic [12:0] PP [4] = '{13'h0dac, 13'h0ea6, 13'h0fa0, 13'h109a};
    localparam logic [7:0]  PC [4] = '{8'h19, 8'h4b, 8'h96, 8'hb4};
    localparam logic [10:0] HZ [4] = '{11'h064, 11'h0c8, 11'h1f4, 11'h3e8};
    logic        clk = 1'b0;
    logic        rst_n, th_loop, pp_loop;
    logic        wr, rd, rvalid, tick, sink1, sink2, lvl, wave, wave_q;
    logic [7:0]  addr, wdata, rdata, pct10;
    logic [12:0] prechg_mv, target_mv, ppath_mv;
    logic [9:0]  cur_ma;
    logic [6:0]  pre_min, temp_c;
    logic [16:0] term_ua;
    logic [10:0] dim_hz;
    int          miscompares = 0, checks_done = 0, n;

    always #2.5 clk = ~clk;
    always @(posedge clk) wave_q <= wave;

    cbc_host cbc_host_i (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid));
    cbc_regs #(.DIM_HALF0(20'h00028), .DIM_HALF1(20'h00014), .DIM_HALF2(20'h00008),
        .DIM_HALF3(20'h00004), .TIMER_DIV(8'h04)) cbc_regs_i (
        .CLK_SYS(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .THERMAL_LOOP_ACTIVE(th_loop), .POWER_PATH_CURRENT_REDUCTION(pp_loop),
        .SAFETY_TIMER_TICK(tick), .TIMER_SLOWDOWN_ENABLE(),
        .PRECHARGE_TRANSITION_SELECT(), .PRECHARGE_TRANSITION_MV(prechg_mv),
        .CHARGE_TARGET_VOLTAGE(), .CHARGE_TARGET_MV(target_mv),
        .CHARGE_CURRENT_SELECT(), .CHARGE_CURRENT_MA(cur_ma),
        .POWER_PATH_THRESHOLD(), .POWER_PATH_THRESHOLD_MV(ppath_mv),
        .PRECHARGE_TIME_SELECT(), .PRECHARGE_TIME_MIN(pre_min),
        .TERMINATION_FACTOR(), .TERMINATION_FACTOR_PCT10(pct10),
        .TERMINATION_CURRENT_UA(term_ua), .CHARGE_TEMPERATURE_WINDOW(),
        .CHARGE_TEMPERATURE_MAX_C(temp_c), .LED_SINK1_ENABLE(sink1),
        .LED_SINK2_ENABLE(sink2), .SINK_LEVEL_SELECT(lvl), .DIMMING_FREQUENCY(),
        .DIMMING_FREQUENCY_HZ(dim_hz), .DIMMING_WAVE(wave));

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        cbc_host_i.read_byte(a, d);
        `CHK(d, e)
    endtask

    // Cycles between two ticks, or between two wave edges
    task automatic gap(input bit w, output int g);
        g = 0;
        while (!(w ? wave !== wave_q : tick)) @(negedge clk);
        do
        begin
            @(negedge clk);
            g++;
        end while (!(w ? wave !== wave_q : tick) && g < 99);
    endtask

    task automatic t_reset;
        rd_chk(`CBC_OFF_SETUP_B, 8'h80);
        rd_chk(`CBC_OFF_SETUP_C, 8'hb2);
        rd_chk(`CBC_OFF_BACKLIGHT_A, 8'h01);
        `CHK(cur_ma, 10'h1f4)
        `CHK(ppath_mv, 13'h109a)
        `CHK(term_ua, 17'h0927c)
        rd_chk(8'h04, 8'h00);
    endtask

    task automatic t_setup_b;
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            d = {1'b1, i[1], 2'(i), 4'ha ^ 4'(i)};
            cbc_host_i.write_byte(`CBC_OFF_SETUP_B, d);
            repeat (4) @(negedge clk);
            `CHK(target_mv, TV[i])
            `CHK(prechg_mv, i[1] ? 13'h09c4 : 13'h0b54)
            rd_chk(`CBC_OFF_SETUP_B, d);
        end
    endtask

    task automatic t_setup_c;
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            d = {2'(i), 2'(i), i[0], 2'(i), i[0]};
            cbc_host_i.write_byte(`CBC_OFF_SETUP_C, d);
            repeat (4) @(negedge clk);
            `CHK(cur_ma, MA[i])
            `CHK(ppath_mv, PP[i])
            `CHK(pre_min, i[0] ? 7'h3c : 7'h1e)
            `CHK(pct10, PC[i])
            `CHK(term_ua, 17'(MA[i]) * 17'(PC[i]))
            `CHK(temp_c, i[0] ? 7'h3c : 7'h2d)
            rd_chk(`CBC_OFF_SETUP_C, d);
        end
    endtask

    task automatic t_backlight;
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            d = {4'hf, i[0], i[1], 2'(i)};
            cbc_host_i.write_byte(`CBC_OFF_BACKLIGHT_A, d);
            repeat (4) @(negedge clk);
            `CHK({sink1, sink2}, {2{i[0]}})
            `CHK(lvl, i[1])
            `CHK(dim_hz, HZ[i])
            rd_chk(`CBC_OFF_BACKLIGHT_A, {4'h0, d[3:0]});
        end
        gap(1'b1, n);
        gap(1'b1, n);
        `CHK(n, 4)
    endtask

    task automatic t_slow;
        gap(1'b0, n);
        `CHK(n, 4)
        @(posedge clk) th_loop <= 1'b1;
        repeat (10) @(negedge clk);
        gap(1'b0, n);
        gap(1'b0, n);
        `CHK(n, 8)
        @(posedge clk) th_loop <= 1'b0;
        pp_loop <= 1'b1;
        repeat (10) @(negedge clk);
        gap(1'b0, n);
        gap(1'b0, n);
        `CHK(n, 8)
        cbc_host_i.write_byte(`CBC_OFF_SETUP_B, 8'h79);
        repeat (10) @(negedge clk);
        gap(1'b0, n);
        gap(1'b0, n);
        `CHK(n, 4)
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        rst_n = 1'b0;
        th_loop = 1'b0;
        pp_loop = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_setup_b();
        t_setup_c();
        t_backlight();
        t_slow();
        tally_and_finish();
    end

    initial
    begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule
